// [hw/irq_enable_defines.svh]
// offsets, field positions, reset values and timing counts of the interrupt enable bank
`ifndef IRQ_ENABLE_DEFINES_SVH
`define IRQ_ENABLE_DEFINES_SVH

`define OFS_INTERRUPT_ENABLE_CLEAR 12'h000
`define OFS_INTERRUPT_ENABLE_SET   12'h004
`define OFS_INTERRUPT_FLAG         12'h008
`define OFS_GUARD_LOCK             12'h00C

`define BIT_CRYSTAL_READY        0
`define BIT_INTERNAL_32KHZ_READY 2
`define BIT_FLL_FINE_LOCK        6
`define BIT_FLL_COARSE_LOCK      7
`define BIT_FLL_REF_STOPPED      8
`define BIT_BROWNOUT_READY       9
`define BIT_BROWNOUT_SYNC_READY  11
`define BIT_PLL_LOCK_GAINED      15
`define BIT_PLL_LOCK_TIMEOUT     17

`define ENABLE_IMPL_MASK  32'h0003_8FFF
`define ENABLE_RESET      32'h0000_0000
`define GUARD_LOCK_RESET  1'b0
`define SYNC_STAGES       2

`endif

// [hw/irq_enable_pkg.sv]
// types shared by the interrupt enable bank
package irq_enable_pkg;

  typedef struct packed {
    logic [11:0] addr;
    logic        write;
    logic [31:0] wdata;
    logic [3:0]  strb;
  } apb_req_t;

  typedef struct packed {
    logic [31:0] rdata;
    logic        slverr;
  } apb_rsp_t;

  typedef enum logic [1:0] {
    ACC_NONE,
    ACC_CLEAR,
    ACC_SET
  } enable_op_t;

endpackage

// [hw/flag_sync.sv]
// two-stage synchroniser for the source interrupt flags
`timescale 1ns/100ps
module flag_sync
  import irq_enable_pkg::*;
#(
  parameter int WIDTH = 32
)
(
  // clock and reset
  input  wire logic             clk,
  input  wire logic             arst_n,
  // flags
  input  wire logic [WIDTH-1:0] flagAsync,
  output logic      [WIDTH-1:0] flagSync
);

  logic [WIDTH-1:0] meta_ff;
  logic [WIDTH-1:0] sync_ff;

  // first stage feeds only the second
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      meta_ff <= '0;
      sync_ff <= '0;
    end
    else
    begin
      meta_ff <= flagAsync;
      sync_ff <= meta_ff;
    end
  end

  assign flagSync = sync_ff;

endmodule // flag_sync

// [hw/byte_merge.sv]
// per-byte lane merge of a write-one mask under byte strobes
`timescale 1ns/100ps
module byte_merge
  import irq_enable_pkg::*;
(
  // request
  input  wire logic [31:0] wdata,
  input  wire logic [3:0]  strb,
  input  wire logic [31:0] implMask,
  // lane mask
  output logic      [31:0] onesMask
);

  genvar lane;
  generate
    for (lane = 0; lane < 4; lane++)
    begin : g_lane
      assign onesMask[lane*8 +: 8] = strb[lane] ? (wdata[lane*8 +: 8] & implMask[lane*8 +: 8])
                                                : 8'h00;
    end
  endgenerate

endmodule // byte_merge

// [hw/sysctrl_interrupt_enable_clear.sv]
// interrupt enable clear/set bank with apb slave and interrupt request
//
// Functional notes
// RQ1: accesses of 8, 16 and 32 bits are taken atomically in one cycle
// RQ2: each byte and halfword lane is written independently through pstrb
// RQ3: asynchronous source flags pass a two-flop synchroniser before use
// RQ4: the access guard lock refuses writes to protected registers with pslverr
// RQ5: enables reset to zero; the bank is write-protected (the guard lock resets to 0, so the bank starts writable)
// RQ6: writing zero to a clear bit leaves the enable unchanged
// RQ7: writing one clears the enable; read returns the enable state
// RQ8: request is high while any flag and its enable are both set
// RQ9: bit 17 pll timeout, 16 lock lost, 15 lock gained
// RQ10: bit 11 brownout sync ready, 10 detect, 9 ready
// RQ11: bit 8 fll reference stopped, bit 7 fll coarse lock
// RQ12: bits 6..0 fll fine, oob, ready, 8mhz, 32khz, xtal32k, xtal ready
// RQ13: set register at offset 0x04 shares layout; writing one sets the enable
// RQ14: bits 31..18 and 14..12 read zero and ignore writes
`timescale 1ns/100ps
`include "irq_enable_defines.svh"
module sysctrl_interrupt_enable_clear
  import irq_enable_pkg::*;
(
  // clock and reset
  input  wire logic        clk,
  input  wire logic        arst_n,
  // apb slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  input  wire logic [3:0]  pstrb,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // access guard
  input  wire logic        guardLock,
  // interrupt sources and request
  input  wire logic [31:0] sourceFlag,
  output logic             irq
);

  apb_req_t   req;
  apb_rsp_t   rsp_ff;
  apb_rsp_t   nxt_rsp;
  enable_op_t op;

  logic [31:0] enable_ff;
  logic [31:0] nxt_enable;
  logic [31:0] flagSync;
  logic [31:0] onesMask;
  logic [31:0] flagLive;
  logic        irq_ff;
  logic        lock_ff;
  logic        nxt_lock;

  wire logic [31:0] implMask = `ENABLE_IMPL_MASK;
  wire logic accessPhase = psel & penable;
  wire logic setupPhase  = psel & ~penable;
  wire logic hitClear    = (req.addr == `OFS_INTERRUPT_ENABLE_CLEAR);
  wire logic hitSet      = (req.addr == `OFS_INTERRUPT_ENABLE_SET);
  wire logic hitFlag     = (req.addr == `OFS_INTERRUPT_FLAG);
  wire logic hitLock     = (req.addr == `OFS_GUARD_LOCK);
  wire logic hitAny      = hitClear | hitSet | hitFlag | hitLock;
  wire logic locked      = guardLock | lock_ff;
  wire logic protHit     = hitClear | hitSet;
  wire logic wrRefused   = req.write & protHit & locked; // [RQ4]
  wire logic wrFlag      = req.write & hitFlag;
  wire logic wrOk        = setupPhase & req.write & hitAny & ~wrRefused & ~wrFlag;

  assign req.addr  = paddr;
  assign req.write = pwrite;
  assign req.wdata = pwdata;
  assign req.strb  = pwrite ? pstrb : 4'h0;

  // source flags cross into the bus clock domain
  flag_sync #(
    .WIDTH (32)
  ) u_flag_sync (
    .clk       (clk),
    .arst_n    (arst_n),
    .flagAsync (sourceFlag),
    .flagSync  (flagSync)
  ); // [RQ3]

  // only implemented bits of enabled byte lanes are written
  byte_merge u_byte_merge (
    .wdata    (req.wdata),
    .strb     (req.strb),
    .implMask (`ENABLE_IMPL_MASK),
    .onesMask (onesMask)
  ); // [RQ1] [RQ2] [RQ14]

  assign op = !wrOk   ? ACC_NONE  :
              hitClear ? ACC_CLEAR :
              hitSet   ? ACC_SET   : ACC_NONE;

  // zeros leave enables alone, ones clear or set them
  always_comb
  begin
    nxt_enable = enable_ff;
    case (op)
      ACC_CLEAR: nxt_enable = enable_ff & ~onesMask; // [RQ6] [RQ7]
      ACC_SET:   nxt_enable = enable_ff | onesMask;  // [RQ13]
      default:   nxt_enable = enable_ff;
    endcase
  end

  // lock bit lives in byte lane 0, write-once until reset
  assign nxt_lock = lock_ff | (wrOk & hitLock & req.strb[0] & req.wdata[0]); // [RQ4]

  assign flagLive = flagSync & `ENABLE_IMPL_MASK;

  // read data and error answer, registered for the access phase
  always_comb
  begin
    nxt_rsp.rdata  = 32'h0000_0000;
    nxt_rsp.slverr = 1'b0;
    if (setupPhase)
    begin
      if (hitClear || hitSet)
      begin
        nxt_rsp.rdata = enable_ff & `ENABLE_IMPL_MASK; // [RQ7] [RQ14]
      end
      else if (hitFlag)
      begin
        nxt_rsp.rdata = flagLive;
      end
      else if (hitLock)
      begin
        nxt_rsp.rdata = {31'h0000_0000, locked};
      end
      nxt_rsp.slverr = ~hitAny | wrRefused | wrFlag;
    end
  end

  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      enable_ff <= `ENABLE_RESET; // [RQ5]
      lock_ff   <= `GUARD_LOCK_RESET;
      rsp_ff    <= '0;
      irq_ff    <= 1'b0;
    end
    else
    begin
      enable_ff <= nxt_enable & `ENABLE_IMPL_MASK;
      lock_ff   <= nxt_lock;
      rsp_ff    <= nxt_rsp;
      irq_ff    <= |(flagLive & enable_ff); // [RQ8]
    end
  end

  // every access completes in its first access cycle
  assign pready  = accessPhase;
  assign prdata  = rsp_ff.rdata;
  assign pslverr = accessPhase & rsp_ff.slverr;
  assign irq     = irq_ff;

  // bit positions of named sources stay within the implemented mask
  a_layout_pll: assert property (@(posedge clk) disable iff (!arst_n)
    implMask[`BIT_PLL_LOCK_TIMEOUT] && implMask[`BIT_PLL_LOCK_GAINED])
    else $error("pll enable bits missing"); // [RQ9]

  a_layout_brownout: assert property (@(posedge clk) disable iff (!arst_n)
    implMask[`BIT_BROWNOUT_SYNC_READY] && implMask[`BIT_BROWNOUT_READY])
    else $error("brownout enable bits missing"); // [RQ10]

  a_layout_fll: assert property (@(posedge clk) disable iff (!arst_n)
    implMask[`BIT_FLL_REF_STOPPED] && implMask[`BIT_FLL_COARSE_LOCK]
    && implMask[`BIT_FLL_FINE_LOCK])
    else $error("fll enable bits missing"); // [RQ11]

  a_layout_osc: assert property (@(posedge clk) disable iff (!arst_n)
    implMask[`BIT_CRYSTAL_READY] && implMask[`BIT_INTERNAL_32KHZ_READY])
    else $error("oscillator enable bits missing"); // [RQ12]

  a_reserved_zero: assert property (@(posedge clk) disable iff (!arst_n)
    (enable_ff & ~`ENABLE_IMPL_MASK) == 32'h0000_0000)
    else $error("reserved enable bit set"); // [RQ14]

  a_clear_ones: assert property (@(posedge clk) disable iff (!arst_n)
    (setupPhase && pwrite && hitClear && !locked)
    |=> ((enable_ff & $past(onesMask)) == 32'h0000_0000))
    else $error("clear write left an enable set"); // [RQ7]

  a_clear_zeros: assert property (@(posedge clk) disable iff (!arst_n)
    (setupPhase && pwrite && hitClear)
    |=> ((enable_ff & ~$past(onesMask)) == ($past(enable_ff) & ~$past(onesMask))))
    else $error("clear write changed an unselected enable"); // [RQ6] [RQ2]

  a_set_ones: assert property (@(posedge clk) disable iff (!arst_n)
    (setupPhase && pwrite && hitSet && !locked)
    |=> ((enable_ff & $past(onesMask)) == $past(onesMask)))
    else $error("set write did not enable"); // [RQ13]

  a_guard_blocks: assert property (@(posedge clk) disable iff (!arst_n)
    (setupPhase && pwrite && protHit && locked)
    |=> ($stable(enable_ff) && pslverr && pready))
    else $error("locked write was accepted"); // [RQ4] [RQ5]

  a_irq_follows: assert property (@(posedge clk) disable iff (!arst_n)
    ##1 (irq == |($past(flagLive) & $past(enable_ff))))
    else $error("interrupt request does not follow flags and enables"); // [RQ8]

  a_sync_delay: assert property (@(posedge clk) disable iff (!arst_n)
    ##3 (flagSync == $past(sourceFlag, 2)))
    else $error("flag synchroniser latency wrong"); // [RQ3]

  a_single_access: assert property (@(posedge clk) disable iff (!arst_n)
    setupPhase |=> (penable ? pready : 1'b1))
    else $error("access not completed in one cycle"); // [RQ1]

endmodule // sysctrl_interrupt_enable_clear

// [test/sysctrl_interrupt_enable_clear_tb.sv]
// self-checking bench for the interrupt enable clear/set bank over apb
`timescale 1ns/100ps
`include "irq_enable_defines.svh"
`define CHK(nm, ex, gt) begin checks++; if ((gt) !== (ex)) begin miscompares++; \
  $display("[FAIL] %s exp %h got %h", nm, ex, gt); end end
module sysctrl_interrupt_enable_clear_tb;
  import irq_enable_pkg::*;

  logic        clk;
  logic        arst_n;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [11:0] paddr;
  logic [31:0] pwdata;
  logic [3:0]  pstrb;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        guardLock;
  logic [31:0] sourceFlag;
  logic        irq;
  logic [31:0] readData;
  logic        slvErr;
  int          miscompares = 0;
  int          checks      = 0;

  sysctrl_interrupt_enable_clear dut (
    .clk        (clk),
    .arst_n     (arst_n),
    .psel       (psel),
    .penable    (penable),
    .pwrite     (pwrite),
    .paddr      (paddr),
    .pwdata     (pwdata),
    .pstrb      (pstrb),
    .prdata     (prdata),
    .pready     (pready),
    .pslverr    (pslverr),
    .guardLock  (guardLock),
    .sourceFlag (sourceFlag),
    .irq        (irq)
  );

  initial clk = 1'b0;
  always #2.5 clk = ~clk;

  // one apb transfer; waits for pready under a bounded count
  task automatic xfer(input logic [11:0] a, input logic w, input logic [31:0] d,
                      input logic [3:0] s);
    int n;
    n = 0;
    @(posedge clk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    pstrb   <= s;
    @(posedge clk);
    penable <= 1'b1;
    forever
    begin
      @(posedge clk);
      if (pready === 1'b1)
        break;
      n++;
      if (n > 50)
      begin
        miscompares++;
        break;
      end
    end
    readData = prdata;
    slvErr   = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic rdchk(input logic [11:0] a, input logic [31:0] ex);
    xfer(a, 1'b0, 32'h0000_0000, 4'h0);
    `CHK("read data", ex, readData)
  endtask

  task automatic print_verdict;
    $display("checks %0d miscompares %0d", checks, miscompares);
    if (miscompares == 0 && checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  initial
  begin
    #5000;
    miscompares++;
    print_verdict();
  end

  initial
  begin
    arst_n = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0; paddr = 12'h000;
    pwdata = 32'h0000_0000; pstrb = 4'h0; guardLock = 1'b0; sourceFlag = 32'h0000_0000;
    repeat (5) @(posedge clk);
    arst_n <= 1'b1;
    rdchk(`OFS_INTERRUPT_ENABLE_CLEAR, 32'h0000_0000);
    xfer(`OFS_INTERRUPT_ENABLE_SET, 1'b1, 32'hFFFF_FFFF, 4'hF);
    rdchk(`OFS_INTERRUPT_ENABLE_CLEAR, 32'h0003_8FFF);
    xfer(`OFS_INTERRUPT_ENABLE_CLEAR, 1'b1, 32'h0000_0000, 4'hF);
    rdchk(`OFS_INTERRUPT_ENABLE_CLEAR, 32'h0003_8FFF);
    xfer(`OFS_INTERRUPT_ENABLE_CLEAR, 1'b1, 32'h0002_0000, 4'h4);
    rdchk(`OFS_INTERRUPT_ENABLE_CLEAR, 32'h0001_8FFF);
    xfer(`OFS_INTERRUPT_ENABLE_CLEAR, 1'b1, 32'hFFFF_0180, 4'h3);
    rdchk(`OFS_INTERRUPT_ENABLE_CLEAR, 32'h0001_8E7F);
    xfer(`OFS_INTERRUPT_ENABLE_CLEAR, 1'b1, 32'hFFFF_0EFF, 4'h2);
    rdchk(`OFS_INTERRUPT_ENABLE_CLEAR, 32'h0001_807F);
    xfer(`OFS_INTERRUPT_ENABLE_CLEAR, 1'b1, 32'h0000_0041, 4'h1);
    rdchk(`OFS_INTERRUPT_ENABLE_SET, 32'h0001_803E);
    // a disabled source must not raise the request
    @(posedge clk);
    sourceFlag <= 32'h0000_0001;
    repeat (5) @(posedge clk);
    `CHK("irq disabled", 1'b0, irq)
    sourceFlag <= 32'h0000_0003;
    @(posedge clk);
    `CHK("irq synced", 1'b0, irq)
    repeat (4) @(posedge clk);
    `CHK("irq enabled", 1'b1, irq)
    xfer(`OFS_INTERRUPT_ENABLE_CLEAR, 1'b1, 32'h0000_0002, 4'hF);
    repeat (3) @(posedge clk);
    `CHK("irq cleared", 1'b0, irq)
    guardLock <= 1'b1;
    xfer(`OFS_INTERRUPT_ENABLE_CLEAR, 1'b1, 32'hFFFF_FFFF, 4'hF);
    `CHK("guard error", 1'b1, slvErr)
    guardLock <= 1'b0;
    rdchk(`OFS_INTERRUPT_ENABLE_CLEAR, 32'h0001_803C);
    rdchk(12'h010, 32'h0000_0000);
    `CHK("unmapped error", 1'b1, slvErr)
    print_verdict();
  end
endmodule // sysctrl_interrupt_enable_clear_tb
